/* File: rtl/afbt_consts.svh */
/*
  Timing constants for the asynchronous flash bus host sequencer.
  Assumes a 125 MHz system clock; counts derive from ns figures.
*/
`ifndef AFBT_CONSTS_SVH
`define AFBT_CONSTS_SVH

`define AFBT_CLK_PERIOD_NS   8
// Minimum times rounded up to whole cycles
`define AFBT_CEIL(ns) \
  (((ns) + `AFBT_CLK_PERIOD_NS - 1) / `AFBT_CLK_PERIOD_NS)
`define AFBT_T_AVQV_NS       95
`define AFBT_T_GLQV_NS       25
`define AFBT_T_WP_NS         60
`define AFBT_T_WPH_NS        30
`define AFBT_T_WHGL_NS       35
`define AFBT_T_PHWL_NS       210
`define AFBT_T_STS_NS        500
`define AFBT_T_SETUP_NS      8
`define AFBT_CYC_AVQV        `AFBT_CEIL(`AFBT_T_AVQV_NS)
`define AFBT_CYC_WP          `AFBT_CEIL(`AFBT_T_WP_NS)
`define AFBT_CYC_WPH         `AFBT_CEIL(`AFBT_T_WPH_NS)
`define AFBT_CYC_WHGL        `AFBT_CEIL(`AFBT_T_WHGL_NS)
`define AFBT_CYC_PHWL        `AFBT_CEIL(`AFBT_T_PHWL_NS)
`define AFBT_CYC_STS         `AFBT_CEIL(`AFBT_T_STS_NS)
`define AFBT_CYC_SETUP       `AFBT_CEIL(`AFBT_T_SETUP_NS)
`define AFBT_CNT_W           8
// Status bits that must all be zero for success
`define AFBT_SR_ERR_MASK     16'h003A
`define AFBT_SR_READY_BIT    7

`endif

/* File: rtl/afbt_host.sv */
/*
  Host-side sequencer driving a NOR flash over its asynchronous bus pins.
  Assumes a 125 MHz clock, data pins synchronous to it, and a device that
  honours its own read, write and busy timing.
*/
// How it works
// - Output enable falls with chip select; access waits the full delay.
// - Host controls writes by write enable; chip select frames it.
// - Write pulse is the overlap of chip select and write enable.
// - Write strobe stays high at least 30 ns between pulses.
// - After a write, wait 35 ns plus address access before reading.
// - Program supply held high until a status read shows bit 7 set and bits 1,3,4,5 zero.
// - After reset release wait 210 ns before the first write.
`timescale 1ns/1ns
`include "afbt_consts.svh"

module afbt_host (
  // Clock and reset
  input  wire logic               clk_sys_in,
  input  wire logic               reset_n_in,
  // Request side
  input  wire logic               req_valid_in,
  input  wire afbt_pkg::afbt_req_t req_in,
  output logic                    req_ready_out,
  output logic                    rsp_valid_out,
  output logic [15:0]             rsp_data_out,
  // Control
  input  wire logic               flash_reset_in,
  input  wire logic               pen_hold_in,
  output logic                    busy_out,
  output logic                    pgm_ok_out,
  // Flash pins
  output afbt_pkg::afbt_pins_t    pins_out,
  input  wire logic [15:0]        dq_in,
  input  wire logic               busy_status_pin_in
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    afbt_pkg::afbt_state_t st;
    logic [`AFBT_CNT_W-1:0] cnt;
    logic [`AFBT_CNT_W-1:0] gap;
    logic [`AFBT_CNT_W-1:0] sts_wait;
    logic                   after_wr;
    logic                   rsp_v;
    logic [15:0]            rdata;
    logic                   is_status;
    logic                   pen;
    logic                   pgm_ok;
    afbt_pkg::afbt_pins_t   pins;
  } afbt_host_state_t;

  afbt_host_state_t s_r;
  afbt_host_state_t s_nxt;

  localparam logic [`AFBT_CNT_W-1:0] CYC_AVQV  = `AFBT_CNT_W'(`AFBT_CYC_AVQV);
  localparam logic [`AFBT_CNT_W-1:0] CYC_WP    = `AFBT_CNT_W'(`AFBT_CYC_WP);
  localparam logic [`AFBT_CNT_W-1:0] CYC_WPH   = `AFBT_CNT_W'(`AFBT_CYC_WPH);
  localparam logic [`AFBT_CNT_W-1:0] CYC_WHGL  = `AFBT_CNT_W'(`AFBT_CYC_WHGL);
  localparam logic [`AFBT_CNT_W-1:0] CYC_PHWL  = `AFBT_CNT_W'(`AFBT_CYC_PHWL);
  localparam logic [`AFBT_CNT_W-1:0] CYC_STS   = `AFBT_CNT_W'(`AFBT_CYC_STS);
  localparam logic [`AFBT_CNT_W-1:0] CYC_SETUP = `AFBT_CNT_W'(`AFBT_CYC_SETUP);
  localparam logic [`AFBT_CNT_W-1:0] ONE       = `AFBT_CNT_W'(1);
  localparam logic [`AFBT_CNT_W-1:0] ZERO      = '0;

  logic idle_ok;
  assign idle_ok = (s_r.st == afbt_pkg::AFBT_ST_IDLE) && (s_r.gap == ZERO);
  assign req_ready_out = idle_ok;
  assign rsp_valid_out = s_r.rsp_v;
  assign rsp_data_out  = s_r.rdata;
  // Busy until the device has had time to pull its pin low
  assign busy_out      = !busy_status_pin_in ||
                         (s_r.sts_wait != ZERO);
  assign pgm_ok_out    = s_r.pgm_ok;
  assign pins_out      = s_r.pins;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.rsp_v = 1'b0;
    if (s_r.cnt != ZERO) begin
      s_nxt.cnt = s_r.cnt - ONE;
    end
    if (s_r.gap != ZERO) begin
      s_nxt.gap = s_r.gap - ONE;
    end
    if (s_r.sts_wait != ZERO) begin
      s_nxt.sts_wait = s_r.sts_wait - ONE;
    end
    // Supply stays high while asked for or until success is seen
    s_nxt.pins.pen = pen_hold_in || s_r.pen;
    unique case (s_r.st)
      afbt_pkg::AFBT_ST_RESET: begin
        s_nxt.pins.rst_n = 1'b1;
        s_nxt.cnt        = CYC_PHWL;
        s_nxt.st         = afbt_pkg::AFBT_ST_RECOVER;
      end
      afbt_pkg::AFBT_ST_RECOVER: begin
        if (s_r.cnt == ZERO) begin
          s_nxt.st = afbt_pkg::AFBT_ST_IDLE;
        end
      end
      afbt_pkg::AFBT_ST_IDLE: begin
        if (flash_reset_in) begin
          s_nxt.pins.rst_n = 1'b0;
          s_nxt.st         = afbt_pkg::AFBT_ST_RESET;
        end else if (req_valid_in && idle_ok) begin
          s_nxt.pins.addr  = req_in.addr;
          s_nxt.pins.dq_o  = req_in.wdata;
          s_nxt.is_status  = (req_in.op == afbt_pkg::AFBT_OP_READ_STATUS);
          if (req_in.op == afbt_pkg::AFBT_OP_WRITE) begin
            s_nxt.pins.dq_oe = 1'b1;
            s_nxt.pins.ce_a  = 1'b0;
            s_nxt.cnt        = CYC_SETUP;
            s_nxt.st         = afbt_pkg::AFBT_ST_WR_SETUP;
          end else begin
            s_nxt.pins.dq_oe = 1'b0;
            s_nxt.pins.ce_a  = 1'b0;
            s_nxt.pins.oe_n  = 1'b0;
            // Reads after a write, array or status, also wait the write-to-read time
            s_nxt.cnt = CYC_AVQV +
                        (s_r.after_wr ? CYC_WHGL : ZERO);
            s_nxt.st  = afbt_pkg::AFBT_ST_RD_WAIT;
          end
        end
      end
      afbt_pkg::AFBT_ST_RD_SETUP: begin
        s_nxt.st = afbt_pkg::AFBT_ST_RD_WAIT;
      end
      afbt_pkg::AFBT_ST_RD_WAIT: begin
        if (s_r.cnt == ZERO) begin
          s_nxt.rdata     = dq_in;
          s_nxt.rsp_v     = 1'b1;
          s_nxt.pins.oe_n = 1'b1;
          s_nxt.pins.ce_a = 1'b1;
          s_nxt.after_wr  = 1'b0;
          if (s_r.is_status && dq_in[`AFBT_SR_READY_BIT] &&
              ((dq_in & `AFBT_SR_ERR_MASK) == 16'h0000)) begin
            s_nxt.pen    = 1'b0;
            s_nxt.pgm_ok = 1'b1;
          end
          s_nxt.st = afbt_pkg::AFBT_ST_IDLE;
        end
      end
      afbt_pkg::AFBT_ST_WR_SETUP: begin
        if (s_r.cnt == ZERO) begin
          s_nxt.pins.we_n = 1'b0;
          s_nxt.cnt       = CYC_WP;
          s_nxt.st        = afbt_pkg::AFBT_ST_WR_PULSE;
        end
      end
      afbt_pkg::AFBT_ST_WR_PULSE: begin
        if (s_r.cnt == ZERO) begin
          s_nxt.pins.we_n = 1'b1;
          // Window starts at the edge that ends the write pulse
          s_nxt.sts_wait  = CYC_STS;
          s_nxt.cnt       = ONE;
          s_nxt.st        = afbt_pkg::AFBT_ST_WR_HIGH;
        end
      end
      afbt_pkg::AFBT_ST_WR_HIGH: begin
        if (s_r.cnt == ZERO) begin
          s_nxt.pins.ce_a  = 1'b1;
          s_nxt.pins.dq_oe = 1'b0;
          s_nxt.after_wr   = 1'b1;
          s_nxt.pen        = pen_hold_in || s_r.pen;
          s_nxt.pgm_ok     = 1'b0;
          s_nxt.gap        = (CYC_WPH > CYC_WHGL) ?
                             CYC_WPH : CYC_WHGL;
          s_nxt.st         = afbt_pkg::AFBT_ST_IDLE;
        end
      end
    endcase
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_r           <= '0;
      s_r.st        <= afbt_pkg::AFBT_ST_RESET;
      s_r.pins.ce_a <= 1'b1;
      s_r.pins.oe_n <= 1'b1;
      s_r.pins.we_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

/* File: rtl/afbt_pkg.sv */
/*
  Types for the asynchronous flash bus host sequencer.
  Assumes afbt_consts.svh is available on the include path.
*/
`include "afbt_consts.svh"

package afbt_pkg;

  typedef enum logic [1:0] {
    AFBT_OP_READ_ARRAY,
    AFBT_OP_READ_STATUS,
    AFBT_OP_WRITE
  } afbt_op_t;

  typedef struct packed {
    afbt_op_t     op;
    logic [23:0]  addr;
    logic [15:0]  wdata;
  } afbt_req_t;

  typedef struct packed {
    logic        rst_n;
    logic        ce_a;
    logic        ce_b;
    logic        ce_c;
    logic        oe_n;
    logic        we_n;
    logic        pen;
    logic [23:0] addr;
    logic [15:0] dq_o;
    logic        dq_oe;
  } afbt_pins_t;

  typedef enum {
    AFBT_ST_RESET,
    AFBT_ST_RECOVER,
    AFBT_ST_IDLE,
    AFBT_ST_RD_SETUP,
    AFBT_ST_RD_WAIT,
    AFBT_ST_WR_SETUP,
    AFBT_ST_WR_PULSE,
    AFBT_ST_WR_HIGH
  } afbt_state_t;

endpackage

/* File: sim/afbt_flash_model.sv */
/* Behavioural flash device on the far side of the host.
   Assumes 16 words of storage are enough; status reads return the
   stored word, so the bench sets status bits by writing them. */
`timescale 1ns/1ns
// ----------------------------------------
// Model
// ----------------------------------------
module afbt_flash_model #(
  parameter int ACC_NS  = 95,
  parameter int BUSY_NS = 2000
) (
  // Pins from the host
  input wire afbt_pkg::afbt_pins_t pins_in,
  // Pins to the host
  output logic [15:0]              dq_out,
  output logic                     busy_out
);
  logic [15:0] mem [16];
  logic        sel;
  logic        wr_act;
  int          pend;
  assign sel = pins_in.rst_n && (pins_in.ce_c ?
    !(pins_in.ce_a && pins_in.ce_b) : !pins_in.ce_a && !pins_in.ce_b);
  assign wr_act = sel && !pins_in.we_n && pins_in.oe_n;
  initial begin
    dq_out = 16'h5A5A;
    busy_out = 1'b1;
    pend = 0;
  end
  // Undriven bus flips every change so stale data never looks valid
  always @(sel or pins_in.oe_n or pins_in.addr) begin
    dq_out = ~dq_out;
    if (sel && !pins_in.oe_n) begin
      #(ACC_NS);
      if (sel && !pins_in.oe_n) dq_out = mem[pins_in.addr[3:0]];
    end
  end
  always @(negedge wr_act) begin
    if (pins_in.rst_n === 1'b1) begin
      mem[pins_in.addr[3:0]] = pins_in.dq_o;
      // Busy span runs apart, so a write inside it is not missed
      fork
        begin
          #100 busy_out = 1'b0;
          pend++;
          #(BUSY_NS) pend--;
          if (pend == 0) busy_out = 1'b1;
        end
      join_none
    end
  end
endmodule

/* File: sim/afbt_host_assertions.sv */
/* Pin-timing checker for the flash host sequencer.
   Assumes it is bound to afbt_host and sees only its ports. */
`timescale 1ns/1ns
// ----------------------------------------
// Checker
// ----------------------------------------
module afbt_host_assertions (
  // Clock and reset
  input wire logic                 clk_sys_in,
  input wire logic                 reset_n_in,
  // Watched ports
  input wire logic                 rsp_valid_out,
  input wire logic                 busy_out,
  input wire logic                 busy_status_pin_in,
  input wire afbt_pkg::afbt_pins_t pins_out
);
  logic [7:0] rec_r;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  // Cycles since the device reset pin last went high, saturating
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) rec_r <= 8'h00;
    else if (!pins_out.rst_n) rec_r <= 8'h00;
    else if (rec_r != 8'hFF) rec_r <= rec_r + 8'h01;
  end
  a_no_overlap: assert property (pins_out.oe_n || pins_out.we_n)
    else $error("read and write strobes overlap");
  a_we_framed: assert property (!pins_out.we_n |-> !pins_out.ce_a
    && !pins_out.ce_b && !pins_out.ce_c) else $error("write unselected");
  a_wp_width: assert property ($fell(pins_out.we_n)
    |-> (!pins_out.we_n)[*8]) else $error("write pulse short");
  a_wph_gap: assert property ($rose(pins_out.we_n)
    |-> pins_out.we_n[*4]) else $error("strobe high gap short");
  a_wr_to_rd: assert property ($rose(pins_out.we_n)
    |-> pins_out.oe_n[*5]) else $error("read too soon after write");
  a_rd_access: assert property ($fell(pins_out.oe_n)
    |-> (!pins_out.oe_n && !pins_out.ce_a)[*8] ##1 (!pins_out.oe_n)[*4])
    else $error("read access cut short");
  a_rsp_src: assert property (rsp_valid_out
    |-> $past(pins_out.oe_n) == 1'b0) else $error("response without read");
  a_busy_pin: assert property (!busy_status_pin_in |-> busy_out)
    else $error("busy pin low but busy clear");
  a_busy_win: assert property ($rose(pins_out.we_n)
    |=> busy_out[*8]) else $error("busy window missing");
  a_rec_wait: assert property (!pins_out.we_n |-> rec_r >= 8'h1B)
    else $error("write too soon after reset");
  c_read: cover property (rsp_valid_out);
  c_write: cover property ($fell(pins_out.we_n));
  c_busy: cover property (!busy_status_pin_in && busy_out);
endmodule

bind afbt_host afbt_host_assertions chk_u (
  .clk_sys_in         (clk_sys_in),
  .reset_n_in         (reset_n_in),
  .rsp_valid_out      (rsp_valid_out),
  .busy_out           (busy_out),
  .busy_status_pin_in (busy_status_pin_in),
  .pins_out           (pins_out)
);

/* File: sim/afbt_host_test.sv */
/* Self-checking bench for the flash host sequencer.
   Assumes the flash model on the pins and the bound checker. */
`timescale 1ns/1ns
// ----------------------------------------
// Bench
// ----------------------------------------
module afbt_host_test;
  logic clk_sys_in, reset_n_in, req_valid_in, flash_reset_in, pen_hold_in;
  logic req_ready_out, rsp_valid_out, busy_out, pgm_ok_out, busy_pin;
  logic [15:0] rsp_data_out, dq_in, q;
  afbt_pkg::afbt_req_t req_in;
  afbt_pkg::afbt_pins_t pins_out;
  int err_count = 0;
  int n_checks = 0;
  afbt_host dut_u (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .req_valid_in(req_valid_in), .req_in(req_in),
    .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
    .rsp_data_out(rsp_data_out), .flash_reset_in(flash_reset_in),
    .pen_hold_in(pen_hold_in), .busy_out(busy_out),
    .pgm_ok_out(pgm_ok_out), .pins_out(pins_out), .dq_in(dq_in),
    .busy_status_pin_in(busy_pin));
  afbt_flash_model flash_u (.pins_in(pins_out), .dq_out(dq_in),
    .busy_out(busy_pin));
  task chk_word(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: word %h, want %h", $time, got, exp);
    end
  endtask
  task chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: flag %b, want %b", $time, got, exp);
    end
  endtask
  task do_req(input afbt_pkg::afbt_op_t op, input logic [23:0] a,
              input logic [15:0] d);
    int n;
    n = 0;
    while (req_ready_out !== 1'b1 && n < 400) begin
      @(negedge clk_sys_in);
      n++;
    end
    chk_bit(req_ready_out, 1'b1);
    req_in = '{op, a, d};
    req_valid_in = 1'b1;
    @(negedge clk_sys_in);
    req_valid_in = 1'b0;
    if (op != afbt_pkg::AFBT_OP_WRITE) begin
      n = 0;
      while (rsp_valid_out !== 1'b1 && n < 40) begin
        @(negedge clk_sys_in);
        n++;
      end
      chk_bit(rsp_valid_out, 1'b1);
      q = rsp_data_out;
    end
  endtask
  task wait_idle;
    int n;
    n = 0;
    while (busy_out !== 1'b0 && n < 1000) begin
      @(negedge clk_sys_in);
      n++;
    end
    chk_bit(busy_out, 1'b0);
  endtask
  task t_recover;
    repeat (26) begin
      @(negedge clk_sys_in);
      chk_bit(req_ready_out, 1'b0);
    end
  endtask
  task t_write_read;
    do_req(afbt_pkg::AFBT_OP_WRITE, 24'h000003, 16'hA5C3);
    do_req(afbt_pkg::AFBT_OP_WRITE, 24'h000004, 16'h3C5A);
    chk_bit(busy_out, 1'b1);
    do_req(afbt_pkg::AFBT_OP_READ_ARRAY, 24'h000003, 16'h0000);
    chk_word(q, 16'hA5C3);
    do_req(afbt_pkg::AFBT_OP_READ_ARRAY, 24'h000004, 16'h0000);
    chk_word(q, 16'h3C5A);
    wait_idle;
  endtask
  task t_status;
    logic [15:0] sv [5];
    sv = '{16'h0080, 16'h0082, 16'h0088, 16'h0090, 16'h00A0};
    for (int i = 0; i < 5; i++) begin
      do_req(afbt_pkg::AFBT_OP_WRITE, 24'h000001, sv[i]);
      wait_idle;
      do_req(afbt_pkg::AFBT_OP_READ_STATUS, 24'h000001, 16'h0000);
      @(negedge clk_sys_in);
      chk_word(q, sv[i]);
      chk_bit(pgm_ok_out, i == 0);
    end
  endtask
  task t_pen_reset;
    pen_hold_in = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    chk_bit(pins_out.pen, 1'b1);
    flash_reset_in = 1'b1;
    @(negedge clk_sys_in);
    flash_reset_in = 1'b0;
    t_recover;
    do_req(afbt_pkg::AFBT_OP_WRITE, 24'h000002, 16'h1234);
    wait_idle;
    pen_hold_in = 1'b0;
    do_req(afbt_pkg::AFBT_OP_READ_ARRAY, 24'h000002, 16'h0000);
    chk_word(q, 16'h1234);
    // Word 1 still holds an error status, so the supply must stay up
    do_req(afbt_pkg::AFBT_OP_READ_STATUS, 24'h000001, 16'h0000);
    @(negedge clk_sys_in);
    chk_bit(pins_out.pen, 1'b1);
    do_req(afbt_pkg::AFBT_OP_WRITE, 24'h000001, 16'h0080);
    wait_idle;
    do_req(afbt_pkg::AFBT_OP_READ_STATUS, 24'h000001, 16'h0000);
    @(negedge clk_sys_in);
    chk_bit(pgm_ok_out, 1'b1);
    chk_bit(pins_out.pen, 1'b0);
  endtask
  task stop_test;
    if (err_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    #200000;
    err_count++;
    stop_test;
  end
  initial begin
    {reset_n_in, req_valid_in, flash_reset_in, pen_hold_in} = 4'h0;
    req_in = '{afbt_pkg::AFBT_OP_READ_ARRAY, 24'h000000, 16'h0000};
    repeat (6) @(negedge clk_sys_in);
    reset_n_in = 1'b1;
    t_recover;
    t_write_read;
    t_status;
    t_pen_reset;
    stop_test;
  end
endmodule
